/* File: core/serial_rx_buffer_pulse_host.sv */
`include "sbuf_consts.svh"

module serial_rx_buffer_pulse_host #(
    parameter int DEPTH = 32,
    parameter int CFG_MIN_CYC = `T_CFG_US * `CYC_PER_US,
    parameter int REQ_MAX_CYC = `T_REQ_MAX_US * `CYC_PER_US,
    parameter int BIT_CYC = `CLK_HZ / `HOST_BAUD
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial input
    input wire logic serial_in,
    // Host data pin
    input wire logic data_i,
    output logic data_o,
    output logic data_oe,
    // Status pins
    output logic ready,
    output logic empty
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [15:0] BIT_T = 16'(BIT_CYC);
    localparam logic [15:0] CFG_T = 16'(CFG_MIN_CYC);
    localparam logic [15:0] REQ_MIN_T = 16'(`T_REQ_MIN_US * `CYC_PER_US);
    localparam logic [15:0] REQ_MAX_T = 16'(REQ_MAX_CYC);
    localparam logic [15:0] RESP_T = 16'(`T_RESP_US * `CYC_PER_US);
    localparam logic [15:0] GAP_T = 16'(`T_GAP_US * `CYC_PER_US);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end
    // A host byte can hold the pin high for nine bit times; a shorter setup limit would mistake it for a pulse
    if (REQ_MAX_CYC >= CFG_MIN_CYC || CFG_MIN_CYC > 65535 || CFG_MIN_CYC <= 9 * BIT_CYC) begin : g_bad_pulse
        $error("Pulse limits out of range");
    end
    if (BIT_CYC * 8 > 65535 || BIT_CYC < 4) begin : g_bad_bit
        $error("BIT_CYC out of range");
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    sbuf_pkg::ctrl_type ctrl_q;
    logic [7:0] addr_q;
    logic configured_q;
    logic matched_q;
    sbuf_pkg::link_state_type state_q;
    logic [15:0] hi_cnt_q;
    logic data_d1_q;
    logic [15:0] timer_q;
    logic [3:0] bit_idx_q;
    logic [9:0] shift_q;
    logic first_q;
    logic data_q;
    logic data_oe_q;
    logic ready_q;
    logic empty_q;
    sbuf_pkg::rx_beat_type in_beat;
    sbuf_pkg::rx_beat_type cfg_beat;
    logic pulse_end;
    logic cfg_pulse;
    logic req_pulse;
    logic req_take;
    logic cfg_listen;
    logic store_ok;
    logic push;
    logic push_ok;
    logic pop;
    logic cfg_done;

    assign data_o = data_q;
    assign data_oe = data_oe_q;
    assign ready = ready_q;
    assign empty = empty_q;

    // ----------------------------------------
    // Receivers
    // ----------------------------------------
    serial_rx_frame u_in_rx (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(!configured_q),
        .invert(ctrl_q.invert),
        .divisor(BIT_T << ctrl_q.baud),
        .line(serial_in),
        .beat(in_beat)
    );

    // Host pin bytes are always inverted 9600 baud
    serial_rx_frame u_cfg_rx (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(!cfg_listen),
        .invert(1'b1),
        .divisor(BIT_T),
        .line(data_i),
        .beat(cfg_beat)
    );

    // ----------------------------------------
    // Pulse measurement
    // ----------------------------------------
    assign cfg_listen = (state_q == sbuf_pkg::LS_CFG_ADDR) || (state_q == sbuf_pkg::LS_CFG_CTRL);
    assign pulse_end = data_d1_q && !data_i;
    assign cfg_pulse = pulse_end && (hi_cnt_q >= CFG_T);
    assign req_pulse = pulse_end && (hi_cnt_q >= REQ_MIN_T) && (hi_cnt_q <= REQ_MAX_T);
    assign req_take = (state_q == sbuf_pkg::LS_IDLE) && configured_q && req_pulse && !cfg_pulse
                      && (count_q != '0);
    assign cfg_done = (state_q == sbuf_pkg::LS_CFG_CTRL) && cfg_beat.valid;

    // Saturating count keeps long holds from wrapping into the request window
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hi_cnt_q <= 16'h0000;
            data_d1_q <= 1'b0;
        end else begin
            data_d1_q <= data_i && !data_oe_q;
            if (!data_i || data_oe_q) begin
                hi_cnt_q <= 16'h0000;
            end else if (hi_cnt_q != CFG_T) begin
                hi_cnt_q <= hi_cnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Configuration and address matching
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET;
            addr_q <= `ADDR_RESET;
            configured_q <= 1'b0;
            matched_q <= 1'b0;
        end else begin
            if (cfg_pulse && (state_q == sbuf_pkg::LS_IDLE || cfg_listen)) begin
                configured_q <= 1'b0;
            end else if ((state_q == sbuf_pkg::LS_CFG_ADDR) && cfg_beat.valid) begin
                addr_q <= cfg_beat.data;
            end else if (cfg_done) begin
                ctrl_q <= cfg_beat.data;
                configured_q <= 1'b1;
                matched_q <= 1'b0;
            end else if (in_beat.brk && ctrl_q.mode == `MODE_ADDR_BRK) begin
                matched_q <= 1'b0;
            end else if (in_beat.valid && !matched_q && in_beat.data == addr_q) begin
                matched_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Byte store
    // ----------------------------------------
    // Mode 11 is undefined and is handled as normal byte mode
    assign store_ok = (ctrl_q.mode != `MODE_ADDR && ctrl_q.mode != `MODE_ADDR_BRK) || matched_q;
    assign push = configured_q && in_beat.valid && store_ok;
    assign push_ok = push && (count_q != FULL);
    assign pop = (state_q == sbuf_pkg::LS_DELAY || state_q == sbuf_pkg::LS_GAP) && (timer_q == 16'h0000);

    always_ff @(posedge ref_clk) begin
        if (push_ok) begin
            mem_q[wr_ptr_q] <= in_beat.data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (cfg_done) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW + 1)'(push_ok) - (AW + 1)'(pop);
        end
    end

    // Status pins lag the count by one cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            ready_q <= (count_q != FULL);
            empty_q <= (count_q == '0);
        end
    end

    // ----------------------------------------
    // Host link sequencer and transmitter
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= sbuf_pkg::LS_IDLE;
            timer_q <= 16'h0000;
            bit_idx_q <= 4'h0;
            shift_q <= 10'h000;
            first_q <= 1'b0;
            data_q <= 1'b0;
            data_oe_q <= 1'b0;
        end else begin
            case (state_q)
                sbuf_pkg::LS_IDLE: begin
                    if (cfg_pulse) begin
                        state_q <= sbuf_pkg::LS_CFG_ADDR;
                    end else if (req_take) begin
                        timer_q <= RESP_T - 16'h0001;
                        first_q <= 1'b1;
                        state_q <= sbuf_pkg::LS_DELAY;
                    end
                end
                sbuf_pkg::LS_CFG_ADDR: begin
                    if (cfg_beat.valid) begin
                        state_q <= sbuf_pkg::LS_CFG_CTRL;
                    end
                end
                sbuf_pkg::LS_CFG_CTRL: begin
                    if (cfg_pulse) begin
                        state_q <= sbuf_pkg::LS_CFG_ADDR;
                    end else if (cfg_beat.valid) begin
                        state_q <= sbuf_pkg::LS_IDLE;
                    end
                end
                sbuf_pkg::LS_DELAY, sbuf_pkg::LS_GAP: begin
                    if (timer_q != 16'h0000) begin
                        timer_q <= timer_q - 16'h0001;
                    end else begin
                        shift_q <= {1'b1, mem_q[rd_ptr_q], 1'b0};
                        data_q <= 1'b1;
                        data_oe_q <= 1'b1;
                        bit_idx_q <= 4'h0;
                        timer_q <= BIT_T - 16'h0001;
                        state_q <= sbuf_pkg::LS_SEND;
                    end
                end
                sbuf_pkg::LS_SEND: begin
                    if (timer_q != 16'h0000) begin
                        timer_q <= timer_q - 16'h0001;
                    end else if (bit_idx_q == `FRAME_LAST) begin
                        data_q <= 1'b0;
                        data_oe_q <= 1'b0;
                        if (ctrl_q.burst && count_q != '0) begin
                            timer_q <= GAP_T - 16'h0001;
                            first_q <= 1'b0;
                            state_q <= sbuf_pkg::LS_GAP;
                        end else begin
                            state_q <= sbuf_pkg::LS_IDLE;
                        end
                    end else begin
                        data_q <= ~shift_q[1];
                        shift_q <= {1'b0, shift_q[9:1]};
                        bit_idx_q <= bit_idx_q + 4'h1;
                        timer_q <= BIT_T - 16'h0001;
                    end
                end
                default: begin
                    state_q <= sbuf_pkg::LS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int RESP_MIN_CYC = `T_RESP_MIN_US * `CYC_PER_US;
    localparam int RESP_MAX_CYC = `T_RESP_MAX_US * `CYC_PER_US;
    localparam int DONE_MIN_CYC = `T_DONE_MIN_US * `CYC_PER_US;
    localparam int DONE_MAX_CYC = `T_DONE_MAX_US * `CYC_PER_US;
    localparam int GAP_CYC = `T_GAP_US * `CYC_PER_US;

    logic [15:0] resp_cnt_q;
    logic [15:0] idle_run_q;

    // Helper counters seen only by the checks below
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resp_cnt_q <= 16'h0000;
            idle_run_q <= 16'h0000;
        end else begin
            if (req_take) begin
                resp_cnt_q <= 16'h0000;
            end else if (resp_cnt_q != 16'hFFFF) begin
                resp_cnt_q <= resp_cnt_q + 16'h0001;
            end
            if (data_oe_q) begin
                idle_run_q <= 16'h0000;
            end else if (idle_run_q != 16'hFFFF) begin
                idle_run_q <= idle_run_q + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_start_window: assert property ($rose(data_oe_q) && first_q |->
        resp_cnt_q >= RESP_MIN_CYC && resp_cnt_q <= RESP_MAX_CYC)
        else $error("Start bit outside response window");
    a_burst_gap: assert property ($rose(data_oe_q) && !first_q |-> idle_run_q == GAP_CYC)
        else $error("Burst gap not exact");
    a_single_done: assert property ($fell(data_oe_q) && first_q && state_q == sbuf_pkg::LS_IDLE |->
        resp_cnt_q >= DONE_MIN_CYC && resp_cnt_q <= DONE_MAX_CYC)
        else $error("Response end outside window");
    a_idle_no_store: assert property (!configured_q |-> count_q == '0 || cfg_listen)
        else $error("Stored data while unconfigured");
    a_addr_gate: assert property (configured_q && !matched_q && !cfg_done
        && (ctrl_q.mode == `MODE_ADDR || ctrl_q.mode == `MODE_ADDR_BRK) |=> count_q <= $past(count_q))
        else $error("Stored before address match");
    a_cfg_clears: assert property (cfg_done |=> count_q == '0 && configured_q ##1 empty_q)
        else $error("Configuration did not clear buffer");
    a_empty_ignore: assert property (pulse_end && state_q == sbuf_pkg::LS_IDLE && count_q == '0
        && !cfg_pulse |=> state_q == sbuf_pkg::LS_IDLE && !data_oe_q)
        else $error("Answered a request while empty");
    a_full_drop: assert property (count_q == FULL && !pop && !cfg_done |=> count_q == FULL)
        else $error("Full buffer changed without pop");
    a_status_pins: assert property (##1 ready_q == ($past(count_q) != FULL)
        && empty_q == ($past(count_q) == '0))
        else $error("Status pins disagree with count");

    c_configured: cover property (cfg_done);
    c_single_sent: cover property ($fell(data_oe_q) && state_q == sbuf_pkg::LS_IDLE);
    c_burst_next: cover property ($rose(data_oe_q) && !first_q);
    c_full_drop: cover property (push && count_q == FULL);

endmodule

/* File: core/sbuf_consts.svh */
`ifndef SBUF_CONSTS_SVH
`define SBUF_CONSTS_SVH


// ----------------------------------------
// Clock and link rates
// ----------------------------------------
`define CLK_HZ 25000000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define HOST_BAUD 9600

// ----------------------------------------
// Times in microseconds
// ----------------------------------------
`define T_CFG_US 1200
`define T_REQ_MIN_US 52
`define T_REQ_MAX_US 1000
`define T_RESP_MIN_US 52
`define T_RESP_MAX_US 78
`define T_RESP_US 65
`define T_GAP_US 52
`define T_DONE_MIN_US 1092
`define T_DONE_MAX_US 1118

// ----------------------------------------
// Field codes, reset values and frame bit indices
// ----------------------------------------
`define MODE_NORMAL 2'h0
`define MODE_ADDR 2'h1
`define MODE_ADDR_BRK 2'h2
`define CTRL_RESET 8'h00
`define ADDR_RESET 8'h00
`define FRAME_LAST 4'h9
`define DATA_LAST 3'h7

`endif

/* File: core/sbuf_pkg.sv */
package sbuf_pkg;

    // Control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic burst;
        logic [1:0] mode;
        logic [1:0] baud;
        logic invert;
        logic [1:0] unused;
    } ctrl_type;

    // One received frame
    typedef struct packed {
        logic valid;
        logic brk;
        logic [7:0] data;
    } rx_beat_type;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_CFG_ADDR,
        LS_CFG_CTRL,
        LS_DELAY,
        LS_SEND,
        LS_GAP
    } link_state_type;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP,
        RX_WAIT_HIGH
    } rx_state_type;

endpackage

/* File: core/serial_rx_frame.sv */
`include "sbuf_consts.svh"

module serial_rx_frame (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic clear,
    input wire logic invert,
    input wire logic [15:0] divisor,
    // Line and result
    input wire logic line,
    output sbuf_pkg::rx_beat_type beat
);

    sbuf_pkg::rx_state_type state_q;
    logic [15:0] timer_q;
    logic [2:0] idx_q;
    logic [7:0] shift_q;
    logic level;

    // Mark reads as one after polarity correction
    assign level = line ^ invert;

    // ----------------------------------------
    // Frame sampling at mid bit
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= sbuf_pkg::RX_IDLE;
            timer_q <= 16'h0000;
            idx_q <= 3'h0;
            shift_q <= 8'h00;
            beat <= '0;
        end else if (clear) begin
            state_q <= sbuf_pkg::RX_IDLE;
            beat <= '0;
        end else begin
            beat.valid <= 1'b0;
            beat.brk <= 1'b0;
            case (state_q)
                sbuf_pkg::RX_IDLE: begin
                    if (!level) begin
                        timer_q <= divisor >> 1;
                        state_q <= sbuf_pkg::RX_START;
                    end
                end
                sbuf_pkg::RX_START: begin
                    if (timer_q != 16'h0000) begin
                        timer_q <= timer_q - 16'h0001;
                    end else if (!level) begin
                        timer_q <= divisor - 16'h0001;
                        idx_q <= 3'h0;
                        state_q <= sbuf_pkg::RX_DATA;
                    end else begin
                        // Glitch shorter than half a bit
                        state_q <= sbuf_pkg::RX_IDLE;
                    end
                end
                sbuf_pkg::RX_DATA: begin
                    if (timer_q != 16'h0000) begin
                        timer_q <= timer_q - 16'h0001;
                    end else begin
                        shift_q <= {level, shift_q[7:1]};
                        timer_q <= divisor - 16'h0001;
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == `DATA_LAST) begin
                            state_q <= sbuf_pkg::RX_STOP;
                        end
                    end
                end
                sbuf_pkg::RX_STOP: begin
                    if (timer_q != 16'h0000) begin
                        timer_q <= timer_q - 16'h0001;
                    end else if (level) begin
                        beat.valid <= 1'b1;
                        beat.data <= shift_q;
                        state_q <= sbuf_pkg::RX_IDLE;
                    end else begin
                        // Zero byte with missing stop bit is a break
                        beat.brk <= (shift_q == 8'h00);
                        state_q <= sbuf_pkg::RX_WAIT_HIGH;
                    end
                end
                sbuf_pkg::RX_WAIT_HIGH: begin
                    if (level) begin
                        state_q <= sbuf_pkg::RX_IDLE;
                    end
                end
                default: begin
                    state_q <= sbuf_pkg::RX_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: sim/host_pin_model.sv */
module host_pin_model #(
    parameter int BIT_CYC = 2604
) (
    // Clock
    input wire logic ref_clk,
    // Pin drive, 0 when released to the pull-down
    output logic host_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Host side of the data pin
    // ----------------------------------------
    // Callers enter and leave just after a rising edge
    initial host_drv = 1'b0;

    // High for n cycles, then release so the pull-down ends the pulse
    task automatic pulse(input int n);
        host_drv = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 host_drv = 1'b0;
    endtask

    // Inverted 8N1: start high, data inverted LSB first, stop low
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b0, ~b, 1'b1};
        for (int i = 0; i < 10; i++) begin
            host_drv = frame[i];
            repeat (BIT_CYC) @(posedge ref_clk);
            #1;
        end
    endtask
endmodule

/* File: sim/serial_rx_buffer_pulse_host_tb.sv */
module serial_rx_buffer_pulse_host_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BIT = 2604;
    localparam int US = 25;

    logic ref_clk;
    logic reset;
    logic serial_in;
    logic data_o;
    logic data_oe;
    logic ready;
    logic empty;
    logic host_drv;
    wire logic pin;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    // Pulled-low pin: device wins only while it drives
    assign pin = data_oe ? data_o : host_drv;

    // Setup limit shortened but kept above a host byte's longest high run; request range covers 1400
    serial_rx_buffer_pulse_host #(.CFG_MIN_CYC(24000), .REQ_MAX_CYC(1500)) dut_u (
        .ref_clk(ref_clk),
        .reset(reset),
        .serial_in(serial_in),
        .data_i(pin),
        .data_o(data_o),
        .data_oe(data_oe),
        .ready(ready),
        .empty(empty)
    );

    host_pin_model #(.BIT_CYC(BIT)) host_u (
        .ref_clk(ref_clk),
        .host_drv(host_drv)
    );

    // ----------------------------------------
    // Clock, timeout, reporting
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 140000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            end_sim();
        end
    end

    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ----------------------------------------
    // Scenario tasks
    // ----------------------------------------
    // Inverted input line: mark is low
    task automatic feed(input logic [7:0] b);
        logic [9:0] f;
        f = ~{1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in = f[i];
            wait_cyc(BIT);
        end
    endtask

    task automatic configure(input logic [7:0] addr, input logic [7:0] ctrl);
        host_u.pulse(24100);
        wait_cyc(1400);
        host_u.send_byte(addr);
        host_u.send_byte(ctrl);
        wait_cyc(100);
        check(empty === 1'b1 && ready === 1'b1, "status after setup");
    endtask

    // Host gives up 84 us after the pulse, past the latest start
    task automatic request(input logic [7:0] exp, input logic has_data);
        int n;
        int m;
        logic [7:0] got;
        n = 0;
        m = 0;
        host_u.pulse(1400);
        while (data_oe !== 1'b1 && n < 84 * US) begin
            wait_cyc(1);
            n++;
        end
        if (!has_data) begin
            check(n == 84 * US, "answer while empty");
            return;
        end
        check(n >= 52 * US && n <= 78 * US, "start delay");
        wait_cyc(BIT / 2);
        check(pin === 1'b1, "start level");
        for (int i = 0; i < 8; i++) begin
            wait_cyc(BIT);
            got[i] = ~pin;
        end
        wait_cyc(BIT);
        check(pin === 1'b0, "stop level");
        while (data_oe === 1'b1 && m < BIT) begin
            wait_cyc(1);
            m++;
        end
        m = m + n + BIT / 2 + 9 * BIT;
        check(m >= 1092 * US && m <= 1118 * US, "answer end");
        check(got === exp, "returned byte");
        wait_cyc(5);
        check(empty === 1'b1 && data_oe === 1'b0, "after answer");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        serial_in = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b0;
        wait_cyc(2);
        check(ready === 1'b1 && empty === 1'b1 && data_oe === 1'b0, "reset state");
        // Inverted input, 9600, normal mode, single byte per request
        configure(8'h20, 8'h04);
        // Empty poll runs while the first byte is still arriving
        fork
            request(8'h00, 1'b0);
            feed(8'hA5);
        join
        wait_cyc(10);
        check(empty === 1'b0 && ready === 1'b1, "one byte held");
        request(8'hA5, 1'b1);
        end_sim();
    end
endmodule
